// file: core/fcd_defs.svh
// command decoder constants: register offsets, fields, command codes, counts
// assumes inclusion by bare name from the modules
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH
// ==========================================
// register byte offsets
`define OFF_CLKDIV 12'h000
`define OFF_STATUS 12'h004
`define OFF_CMD 12'h008
`define OFF_PARAM0 12'h00C
`define OFF_PARAM1 12'h010
`define OFF_PARAM2 12'h014
`define OFF_PPROT 12'h018
`define OFF_DPROT 12'h01C
`define OFF_RESULT 12'h020
`define OFF_OTP_ADDR 12'h024
// ==========================================
// status fields
`define ST_COMMAND_COMPLETE_FLAG 0
`define ST_ACCESS_ERROR_FLAG 1
`define ST_PVIOL 2
`define ST_DIVLD 3
`define ST_SECURED 4
`define ST_VERR 5
// protection fields
`define PP_LDIS 0
`define PP_HDIS 1
`define PP_OPEN 2
`define DP_OPEN 0
// parameter0: bit 16 selects data array
`define P0_DATA_SEL 16
// ==========================================
// command codes
`define CMD_EV_ALL 8'h01
`define CMD_EV_BLK 8'h02
`define CMD_EV_PSEC 8'h03
`define CMD_RD_ONCE 8'h04
`define CMD_PRG_P 8'h06
`define CMD_PRG_ONCE 8'h07
`define CMD_ERS_ALL 8'h08
`define CMD_ERS_BLK 8'h09
`define CMD_ERS_PSEC 8'h0A
`define CMD_UNSEC 8'h0B
`define CMD_BACKDOOR 8'h0C
`define CMD_USR_MARGIN 8'h0D
`define CMD_FLD_MARGIN 8'h0E
`define CMD_EV_DSEC 8'h10
`define CMD_PRG_D 8'h11
`define CMD_ERS_DSEC 8'h12
// ==========================================
// sizes and timing
`define OTP_WORDS 16
`define OTP_AW 4
`define MAX_DWORDS 4
`define OP_CYCLES 8'h10
`define KEY_RESET 32'h5A5A_A5A5
`endif

// file: core/fcd_engine.sv
// array operation engine: timed stand-in for the array algorithm
// assumes one start pulse per operation while idle; done pulses once
`timescale 1ns/10ps
`include "fcd_defs.svh"
module fcd_engine (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cen,
	input wire logic array_fail,
	fcd_op_if.eng bus
);
	typedef struct packed {
		logic [7:0] cnt;
		logic busy;
		logic done;
		logic fail;
	} eng_s;
	eng_s st_ff, nxt_st;
	// ==========================================
	// operation timer
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (st_ff.busy) begin
			if (st_ff.cnt == 8'h00) begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
				nxt_st.fail = array_fail & (bus.op == fcd_pkg::OP_VERIFY);
			end else begin
				nxt_st.cnt = st_ff.cnt - 8'h01;
			end
		end else if (bus.start) begin
			nxt_st.busy = 1'b1;
			nxt_st.cnt = `OP_CYCLES;
			nxt_st.fail = 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else if (cen) begin
			st_ff <= nxt_st;
		end
	end
	assign bus.busy = st_ff.busy;
	assign bus.done = st_ff.done;
	assign bus.fail = st_ff.fail;
endmodule // fcd_engine

// file: core/fcd_op_if.sv
// carrier between the decoder and the array engine
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface fcd_op_if;
	logic start;
	fcd_pkg::op_e op;
	fcd_pkg::scope_e scope;
	logic data_sel;
	logic [31:0] addr;
	logic [15:0] count;
	logic busy;
	logic done;
	logic fail;
	modport ctrl (output start, op, scope, data_sel, addr, count, input busy, done, fail);
	modport eng (input start, op, scope, data_sel, addr, count, output busy, done, fail);
endinterface

// file: core/fcd_otp.sv
// one-time-programmable field: 16 words, each writable once
// assumes writes arrive only from the decoder
`timescale 1ns/10ps
`include "fcd_defs.svh"
module fcd_otp (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cen,
	input wire logic wr,
	input wire logic [`OTP_AW-1:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata,
	output logic used
);
	typedef struct packed {
		logic [`OTP_WORDS-1:0][31:0] mem;
		logic [`OTP_WORDS-1:0] written;
	} otp_s;
	otp_s st_ff, nxt_st;
	// ==========================================
	// once-only write; a second write leaves the word alone
	always_comb begin
		nxt_st = st_ff;
		if (wr && !st_ff.written[addr]) begin
			nxt_st.mem[addr] = wdata;
			nxt_st.written[addr] = 1'b1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else if (cen) begin
			st_ff <= nxt_st;
		end
	end
	assign rdata = st_ff.mem[addr];
	assign used = st_ff.written[addr];
endmodule // fcd_otp

// file: core/fcd_pkg.sv
// types shared by the command decoder modules
// assumes fcd_defs.svh on the include path
package fcd_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CHECK = 3'b001,
		ST_EXEC = 3'b010,
		ST_DONE = 3'b011
	} seq_e;
	// array operation kinds issued to the array engine
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_VERIFY = 3'b001,
		OP_PROGRAM = 3'b010,
		OP_ERASE = 3'b011,
		OP_MARGIN = 3'b100
	} op_e;
	typedef enum logic [1:0] {
		SC_BLOCK = 2'b00,
		SC_ALL = 2'b01,
		SC_SECTOR = 2'b10,
		SC_RANGE = 2'b11
	} scope_e;
endpackage

// file: core/flash_command_decoder.sv
// flash command decoder: APB registers, command check and dispatch
// assumes an APB master on pclk; array engine and OTP field instantiated here
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/10ps
`include "fcd_defs.svh"
module flash_command_decoder (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cen,
	input wire logic special_mode,
	input wire logic array_fail,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [7:0] margin_level_p,
	output logic [7:0] margin_level_d,
	output logic secured
);
	typedef struct packed {
		fcd_pkg::seq_e seq;
		logic [7:0] clkdiv;
		logic divld;
		logic command_complete_flag;
		logic access_error_flag;
		logic pviol;
		logic verr;
		logic secured;
		logic [7:0] cmd;
		logic [31:0] p0;
		logic [31:0] p1;
		logic [31:0] p2;
		logic [2:0] pprot;
		logic dprot;
		logic [31:0] result;
		logic [7:0] mlev_p;
		logic [7:0] mlev_d;
		logic unsec_verify;
		logic eng_start;
		fcd_pkg::op_e op;
		fcd_pkg::scope_e scope;
		logic otp_wr;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic mode_m1;
		logic mode_m2;
	} dec_s;
	dec_s st_ff, nxt_st;
	fcd_op_if opb ();
	logic [31:0] otp_rdata;
	logic otp_used;
	logic access;
	logic valid_code;
	logic prog_erase;
	logic data_sel;
	logic prot_ok;
	// ==========================================
	// sub-blocks
	fcd_engine u_engine (
		.pclk(pclk),
		.presetn(presetn),
		.cen(cen),
		.array_fail(array_fail),
		.bus(opb.eng)
	);
	fcd_otp u_otp (
		.pclk(pclk),
		.presetn(presetn),
		.cen(cen),
		.wr(st_ff.otp_wr),
		.addr(st_ff.p1[`OTP_AW-1:0]),
		.wdata(st_ff.p2),
		.rdata(otp_rdata),
		.used(otp_used)
	);
	assign opb.start = st_ff.eng_start;
	assign opb.op = st_ff.op;
	assign opb.scope = st_ff.scope;
	assign opb.data_sel = st_ff.p0[`P0_DATA_SEL];
	assign opb.addr = st_ff.p1;
	assign opb.count = st_ff.p2[15:0];
	// ==========================================
	// command classification
	assign access = psel & penable & ~st_ff.pready;
	assign data_sel = st_ff.p0[`P0_DATA_SEL];
	always_comb begin
		case (st_ff.cmd)
			`CMD_EV_ALL, `CMD_EV_BLK, `CMD_EV_PSEC, `CMD_RD_ONCE, `CMD_PRG_P,
			`CMD_PRG_ONCE, `CMD_ERS_BLK, `CMD_ERS_PSEC, `CMD_BACKDOOR,
			`CMD_USR_MARGIN, `CMD_EV_DSEC, `CMD_PRG_D, `CMD_ERS_DSEC: valid_code = 1'b1;
			`CMD_ERS_ALL, `CMD_UNSEC, `CMD_FLD_MARGIN: valid_code = st_ff.mode_m2;
			default: valid_code = 1'b0;
		endcase
		case (st_ff.cmd)
			`CMD_PRG_P, `CMD_PRG_ONCE, `CMD_ERS_ALL, `CMD_ERS_BLK, `CMD_ERS_PSEC,
			`CMD_UNSEC, `CMD_PRG_D, `CMD_ERS_DSEC: prog_erase = 1'b1;
			default: prog_erase = 1'b0;
		endcase
		// full-block protection check
		case (st_ff.cmd)
			`CMD_ERS_ALL: prot_ok = (&st_ff.pprot) & st_ff.dprot;
			`CMD_ERS_BLK: begin
				if (data_sel) begin
					prot_ok = st_ff.dprot;
				end else begin
					prot_ok = &st_ff.pprot;
				end
			end
			default: prot_ok = 1'b1;
		endcase
	end
	// ==========================================
	// registers, launch and sequencing
	always_comb begin
		nxt_st = st_ff;
		nxt_st.eng_start = 1'b0;
		nxt_st.otp_wr = 1'b0;
		nxt_st.pready = access;
		nxt_st.pslverr = 1'b0;
		// mode pin is asynchronous to pclk: two flops before use
		nxt_st.mode_m1 = special_mode;
		nxt_st.mode_m2 = st_ff.mode_m1;
		if (access) begin
			nxt_st.pslverr = 1'b0;
			nxt_st.prdata = 32'h0000_0000;
			if (pwrite) begin
				case (paddr)
					`OFF_CLKDIV: begin
						if (st_ff.command_complete_flag) begin
							nxt_st.clkdiv = pwdata[7:0];
							nxt_st.divld = 1'b1;
						end
					end
					`OFF_STATUS: begin
						// access_error_flag and pviol clear by writing one; launch on command_complete_flag write
						if (pwdata[`ST_ACCESS_ERROR_FLAG]) nxt_st.access_error_flag = 1'b0;
						if (pwdata[`ST_PVIOL]) nxt_st.pviol = 1'b0;
						if (pwdata[`ST_COMMAND_COMPLETE_FLAG] && st_ff.command_complete_flag && !st_ff.access_error_flag && !st_ff.pviol) begin
							nxt_st.command_complete_flag = 1'b0;
							nxt_st.seq = fcd_pkg::ST_CHECK;
						end
					end
					`OFF_CMD: if (st_ff.command_complete_flag) nxt_st.cmd = pwdata[7:0];
					`OFF_PARAM0: if (st_ff.command_complete_flag) nxt_st.p0 = pwdata;
					`OFF_PARAM1: if (st_ff.command_complete_flag) nxt_st.p1 = pwdata;
					`OFF_PARAM2: if (st_ff.command_complete_flag) nxt_st.p2 = pwdata;
					`OFF_PPROT: if (st_ff.command_complete_flag) nxt_st.pprot = pwdata[2:0];
					`OFF_DPROT: if (st_ff.command_complete_flag) nxt_st.dprot = pwdata[0];
					`OFF_RESULT, `OFF_OTP_ADDR: ;
					default: nxt_st.pslverr = 1'b1;
				endcase
			end else begin
				case (paddr)
					`OFF_CLKDIV: nxt_st.prdata = {24'h000000, st_ff.clkdiv};
					`OFF_STATUS: begin
						nxt_st.prdata[`ST_COMMAND_COMPLETE_FLAG] = st_ff.command_complete_flag;
						nxt_st.prdata[`ST_ACCESS_ERROR_FLAG] = st_ff.access_error_flag;
						nxt_st.prdata[`ST_PVIOL] = st_ff.pviol;
						nxt_st.prdata[`ST_DIVLD] = st_ff.divld;
						nxt_st.prdata[`ST_SECURED] = st_ff.secured;
						nxt_st.prdata[`ST_VERR] = st_ff.verr;
					end
					`OFF_CMD: nxt_st.prdata = {24'h000000, st_ff.cmd};
					`OFF_PARAM0: nxt_st.prdata = st_ff.p0;
					`OFF_PARAM1: nxt_st.prdata = st_ff.p1;
					`OFF_PARAM2: nxt_st.prdata = st_ff.p2;
					`OFF_PPROT: nxt_st.prdata = {29'h00000000, st_ff.pprot};
					`OFF_DPROT: nxt_st.prdata = {31'h00000000, st_ff.dprot};
					`OFF_RESULT: nxt_st.prdata = st_ff.result;
					`OFF_OTP_ADDR: nxt_st.prdata = {31'h00000000, otp_used};
					default: nxt_st.pslverr = 1'b1;
				endcase
			end
		end
		// command sequencer
		case (st_ff.seq)
			fcd_pkg::ST_IDLE: ;
			fcd_pkg::ST_CHECK: begin
				nxt_st.seq = fcd_pkg::ST_DONE;
				nxt_st.verr = 1'b0;
				if (!valid_code) begin
					nxt_st.access_error_flag = 1'b1;
				end else if (prog_erase && !st_ff.divld) begin
					nxt_st.access_error_flag = 1'b1;
				end else if (!prot_ok) begin
					nxt_st.pviol = 1'b1;
				end else begin
					nxt_st.eng_start = 1'b1;
					nxt_st.seq = fcd_pkg::ST_EXEC;
					nxt_st.scope = fcd_pkg::SC_BLOCK;
					nxt_st.op = fcd_pkg::OP_NONE;
					case (st_ff.cmd)
						`CMD_EV_ALL: begin
							nxt_st.op = fcd_pkg::OP_VERIFY;
							nxt_st.scope = fcd_pkg::SC_ALL;
						end
						`CMD_EV_BLK: nxt_st.op = fcd_pkg::OP_VERIFY;
						`CMD_EV_PSEC, `CMD_EV_DSEC: begin
							nxt_st.op = fcd_pkg::OP_VERIFY;
							nxt_st.scope = fcd_pkg::SC_RANGE;
						end
						`CMD_RD_ONCE: begin
							nxt_st.result = otp_rdata;
							nxt_st.eng_start = 1'b0;
							nxt_st.seq = fcd_pkg::ST_DONE;
						end
						`CMD_PRG_P: begin
							nxt_st.op = fcd_pkg::OP_PROGRAM;
							nxt_st.scope = fcd_pkg::SC_RANGE;
						end
						`CMD_PRG_ONCE: begin
							nxt_st.eng_start = 1'b0;
							nxt_st.seq = fcd_pkg::ST_DONE;
							if (otp_used) begin
								nxt_st.access_error_flag = 1'b1;
							end else begin
								nxt_st.otp_wr = 1'b1;
							end
						end
						`CMD_ERS_ALL: begin
							nxt_st.op = fcd_pkg::OP_ERASE;
							nxt_st.scope = fcd_pkg::SC_ALL;
						end
						`CMD_ERS_BLK: nxt_st.op = fcd_pkg::OP_ERASE;
						`CMD_ERS_PSEC, `CMD_ERS_DSEC: begin
							nxt_st.op = fcd_pkg::OP_ERASE;
							nxt_st.scope = fcd_pkg::SC_SECTOR;
						end
						`CMD_UNSEC: begin
							nxt_st.op = fcd_pkg::OP_ERASE;
							nxt_st.scope = fcd_pkg::SC_ALL;
							nxt_st.unsec_verify = 1'b1;
						end
						`CMD_BACKDOOR: begin
							nxt_st.eng_start = 1'b0;
							nxt_st.seq = fcd_pkg::ST_DONE;
							if (st_ff.p1 == `KEY_RESET) nxt_st.secured = 1'b0;
							else nxt_st.verr = 1'b1;
						end
						`CMD_USR_MARGIN, `CMD_FLD_MARGIN: begin
							nxt_st.eng_start = 1'b0;
							nxt_st.seq = fcd_pkg::ST_DONE;
							if (data_sel) nxt_st.mlev_d = st_ff.p1[7:0];
							else nxt_st.mlev_p = st_ff.p1[7:0];
						end
						`CMD_PRG_D: begin
							if (st_ff.p2[2:0] == 3'h0 || st_ff.p2[2:0] > 3'h4) begin
								nxt_st.access_error_flag = 1'b1;
								nxt_st.eng_start = 1'b0;
								nxt_st.seq = fcd_pkg::ST_DONE;
							end else begin
								nxt_st.op = fcd_pkg::OP_PROGRAM;
								nxt_st.scope = fcd_pkg::SC_RANGE;
							end
						end
						default: begin
							nxt_st.eng_start = 1'b0;
							nxt_st.seq = fcd_pkg::ST_DONE;
						end
					endcase
				end
			end
			fcd_pkg::ST_EXEC: begin
				if (opb.done) begin
					if (st_ff.unsec_verify) begin
						// second pass of unsecure: verify what was just erased
						nxt_st.unsec_verify = 1'b0;
						nxt_st.op = fcd_pkg::OP_VERIFY;
						nxt_st.eng_start = 1'b1;
						nxt_st.secured = 1'b0;
					end else begin
						nxt_st.verr = opb.fail;
						nxt_st.seq = fcd_pkg::ST_DONE;
					end
				end
			end
			fcd_pkg::ST_DONE: begin
				nxt_st.command_complete_flag = 1'b1;
				nxt_st.seq = fcd_pkg::ST_IDLE;
			end
			default: nxt_st.seq = fcd_pkg::ST_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.command_complete_flag <= 1'b1;
			st_ff.secured <= 1'b1;
		end else if (cen) begin
			st_ff <= nxt_st;
		end
	end
	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign margin_level_p = st_ff.mlev_p;
	assign margin_level_d = st_ff.mlev_d;
	assign secured = st_ff.secured;
endmodule // flash_command_decoder

// file: test/fcd_props.sv
// port checker for the flash command decoder
// assumes binding onto flash_command_decoder, one pclk domain
`timescale 1ns/10ps
`include "fcd_defs.svh"
module fcd_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] margin_level_p,
	input wire logic [7:0] margin_level_d,
	input wire logic secured
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// bus answer timing
	wire acc = psel && penable;
	pready_wait_a: assert property (acc && !pready |=> pready)
		else $error("pready not one cycle after access");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	pready_cause_a: assert property (pready |-> $past(acc))
		else $error("pready without access");
	// ==========================================
	// error response follows the address map
	slverr_qual_a: assert property (pslverr |-> pready)
		else $error("pslverr outside answer");
	unmapped_err_a: assert property (pready && paddr > `OFF_OTP_ADDR |-> pslverr)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (pready && paddr <= `OFF_OTP_ADDR && paddr[1:0] == 2'h0
		|-> !pslverr)
		else $error("mapped access refused");
	// ==========================================
	// security only released by commands, only restored by reset
	secured_reset_a: assert property ($rose(presetn) |-> secured)
		else $error("secured low after reset");
	secured_norise_a: assert property (!secured |=> !secured)
		else $error("secured rose without reset");
	// one margin command touches one array only
	margin_one_a: assert property ($changed(margin_level_p) |-> $stable(margin_level_d))
		else $error("both margin levels moved");
	cover property (pready && pslverr);
	cover property ($fell(secured));
	cover property ($changed(margin_level_d));
endmodule // fcd_props

bind flash_command_decoder fcd_props u_fcd_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.margin_level_p(margin_level_p), .margin_level_d(margin_level_d), .secured(secured));

// file: test/tb_top.sv
// self-checking bench for the flash command decoder over apb
// assumes fcd_defs.svh on the include path; cen held high throughout
`timescale 1ns/10ps
`include "fcd_defs.svh"
module tb_top;
	logic pclk, presetn, cen, special_mode, array_fail;
	logic psel, penable, pwrite, pready, pslverr, secured, e, b;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, p1;
	logic [7:0] margin_level_p, margin_level_d;
	int fails, checks_done, cyc;
	// ==========================================
	// rows: code, pprot, dprot, count, nibble {data sel, special, access_error_flag, pviol}
	logic [23:0] rows [27] = '{24'h010010, 24'h020010, 24'h030010, 24'h100018,
		24'h040010, 24'h060010, 24'h070010, 24'h070012, 24'h087114, 24'h083115,
		24'h097010, 24'h096011, 24'h090118, 24'h090019, 24'h0A0010, 24'h120018,
		24'h0D0010, 24'h0D0018, 24'h0E0012, 24'h0E0014, 24'h110048, 24'h11000A,
		24'h11005A, 24'h050012, 24'hFF0012, 24'h000012, 24'h0B7114};
	flash_command_decoder u_flash_command_decoder (.pclk(pclk), .presetn(presetn),
		.cen(cen), .special_mode(special_mode), .array_fail(array_fail), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.margin_level_p(margin_level_p), .margin_level_d(margin_level_d),
		.secured(secured));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// ==========================================
	// apb master: holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 40) fails++;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
		checks_done++;
		if (x !== y) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, x, y);
		end
	endtask
	// load, launch, sample once while busy, then poll until complete
	task automatic run(input logic [23:0] r, input logic [31:0] pa);
		int n;
		special_mode <= r[2];
		apb(1'b1, `OFF_PPROT, {29'h0, r[14:12]});
		apb(1'b1, `OFF_DPROT, {31'h0, r[8]});
		apb(1'b1, `OFF_PARAM0, {15'h0, r[3], 16'h0});
		apb(1'b1, `OFF_PARAM1, pa);
		apb(1'b1, `OFF_PARAM2, {28'h0, r[7:4]});
		apb(1'b1, `OFF_CMD, {24'h0, r[23:16]});
		apb(1'b1, `OFF_STATUS, 32'h1);
		apb(1'b0, `OFF_STATUS, 32'h0);
		b = q[0];
		n = 0;
		while (q[0] !== 1'b1 && n < 60) begin
			apb(1'b0, `OFF_STATUS, 32'h0);
			n++;
		end
	endtask
	task automatic rst;
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic print_verdict;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// hang guard, well above the expected run length
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			print_verdict;
		end
	end
	// ==========================================
	// main sequence
	initial begin
		presetn = 1'b0;
		cen = 1'b1;
		special_mode = 1'b0;
		array_fail = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rst;
		run(24'h060010, 32'h0);
		chk("access_error_flag nodiv", 1'b1, q[1]);
		apb(1'b1, `OFF_STATUS, 32'h6);
		apb(1'b1, `OFF_CLKDIV, 32'h18);
		apb(1'b0, `OFF_STATUS, 32'h0);
		chk("divld", 1'b1, q[3]);
		apb(1'b0, 12'h040, 32'h0);
		chk("unmapped", 1'b1, e);
		// a failing verify must still complete and report
		array_fail <= 1'b1;
		run(24'h010010, 32'h0);
		chk("busy", 1'b0, b);
		chk("verr", 1'b1, q[5]);
		array_fail <= 1'b0;
		apb(1'b1, `OFF_STATUS, 32'h26);
		for (int i = 0; i < 27; i++) begin
			p1 = (rows[i][23:16] == 8'h07) ? 32'h5 : i;
			run(rows[i], p1);
			chk("access_error_flag", rows[i][1], q[1]);
			chk("pviol", rows[i][0], q[2]);
			chk("command_complete_flag", 1'b1, q[0]);
			if (rows[i][23:16] == 8'h0D)
				chk("margin", p1[7:0], rows[i][3] ? margin_level_d : margin_level_p);
			apb(1'b1, `OFF_STATUS, 32'h6);
		end
		chk("unsecured", 1'b0, secured);
		// second reset in mid-run restores security and status
		rst;
		chk("sec rst", 1'b1, secured);
		apb(1'b0, `OFF_STATUS, 32'h0);
		chk("status rst", 32'h11, {26'h0, q[5:0]});
		run(24'h0C0010, 32'h1234_5678);
		chk("key bad", 1'b1, secured);
		apb(1'b1, `OFF_STATUS, 32'h6);
		run(24'h0C0010, `KEY_RESET);
		chk("key ok", 1'b0, secured);
		print_verdict;
	end
endmodule // tb_top
